// File: adc_seq_defines.svh
// Purpose: Constants for the converter input select and sequencer
// Assumes: 10 MHz core clock
// Notes: Codes, counts and reset values
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define SAMPLE_CYCLES 5'h04
`define CONVERT_CYCLES 5'h0c
`define TOTAL_CYCLES 5'h10
`define SRC_BANDGAP 3'h1
`define SRC_GND_LO 3'h2
`define SRC_GND_HI 3'h4
`define REF_SUPPLY_CODE 2'h1
`define RESULT_RESET 12'h000
`define RESULT_FULL_SCALE 12'hfff
`define DIV_RESET 3'h0

`endif

// File: adc_seq_pkg.sv
// Purpose: Types for the converter input select and sequencer
// Assumes: Nothing
// Notes: Constants live in the defines header
package adc_seq_pkg;
    typedef enum logic [1:0] {
        SRC_FLOAT,
        SRC_PIN,
        SRC_BANDGAP,
        SRC_GROUND
    } input_src_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_SAMPLE,
        ST_CONVERT
    } seq_state_t;
endpackage

// File: adc_tick_if.sv
// Purpose: Carries the converter clock tick between modules
// Assumes: One core clock
// Notes: Tick is a one-cycle pulse
`timescale 1ns/10ps
interface adc_tick_if;
    logic [2:0] div_sel;
    logic restart;
    logic tick;
    modport gen (input div_sel, input restart, output tick);
    modport use_side (output div_sel, output restart, input tick);
endinterface

// File: adc_clk_divider.sv
// Purpose: Converter clock tick from the core clock
// Assumes: Divider code held stable during a conversion
// Notes: Tick every 2**div_sel core cycles
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module adc_clk_divider (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Tick link
    adc_tick_if.gen tick_bus
);
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;
    logic [6:0] limit;

    always_comb begin
        limit = 7'((8'h01 << tick_bus.div_sel) - 8'h01);
        nxt_cnt = cnt_ff + 7'h01;
        nxt_tick = 1'b0;
        if (tick_bus.restart) begin
            nxt_cnt = 7'h00;
        end else if (cnt_ff >= limit) begin
            nxt_cnt = 7'h00;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_ff <= 7'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_bus.tick = tick_ff;
endmodule

// File: adc_input_select_and_sequencer.sv
// Purpose: Pin muxing, input select and conversion sequencing of the converter
// Assumes: Firmware drives the control bits as plain synchronous inputs
// Notes: Analog core gives its result on i_core_result at the last convert tick
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

// Functional notes
// - Analog-enabled pin goes to the mux; its other functions are disabled.
// - Pull-up of an analog-enabled pin is disconnected.
// - Analog enable overrides the pin direction setting.
// - Source 000 or 101-111 with channel 0-7 picks analog pin 0-7.
// - Source 000 or 101-111 with channel 8-15 leaves the input floating.
// - Source 001 with channel 8-15 selects the bandgap.
// - Source 010-100 with channel 8-15 ties the input to ground.
// - Conversion is 4 sampling plus 12 converting ticks, 16 total.
// - Conversion runs in hardware without stalling the processor.
// - Start low-high-low; high resets, falling edge launches conversion.
// - Busy high during conversion, low at end; result then readable.
// - Power enable low switches the converter off completely.
// - Result is 12-bit unsigned, full scale all ones, step reference/4096.
// - At completion set the interrupt flag, raise interrupt if enabled.
// - Reference code 01 uses supply; other codes use the external pin.
// - Divider code 000-111 divides the system clock by 1 to 128.
module adc_input_select_and_sequencer (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Pin configuration
    input wire logic [7:0] i_pin_analog_enables,
    input wire logic [7:0] i_port_dir_input,
    input wire logic [7:0] i_port_pullup_en,
    // Converter control
    input wire logic i_converter_power_enable,
    input wire logic i_start,
    input wire logic [2:0] i_conv_clock_divider,
    input wire logic [2:0] i_internal_source_select,
    input wire logic [3:0] i_external_channel_select,
    input wire logic [1:0] i_reference_source_select,
    input wire logic i_result_format_select,
    // Interrupt control
    input wire logic i_global_irq_enable,
    input wire logic i_conversion_irq_enable,
    input wire logic i_irq_flag_clear,
    // Analog core
    input wire logic [11:0] i_core_result,
    // Pin controls
    output logic [7:0] o_pin_digital_enable,
    output logic [7:0] o_pin_dir_input,
    output logic [7:0] o_pin_pullup_on,
    output logic [7:0] o_pin_to_mux,
    // Analog controls
    output logic [1:0] o_input_source,
    output logic [2:0] o_channel_index,
    output logic o_ref_from_supply,
    output logic o_analog_power_on,
    output logic o_sample_hold,
    output logic o_core_reset,
    // Status and result
    output logic o_conversion_busy_flag,
    output logic o_conversion_irq_flag,
    output logic o_conversion_irq,
    output logic o_result_format,
    output logic [7:0] o_result_high_reg,
    output logic [7:0] o_result_low_reg
);
    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    logic [7:0] dig_en_ff, dir_in_ff, pull_ff, to_mux_ff;
    logic [7:0] nxt_dig_en, nxt_dir_in, nxt_pull, nxt_to_mux;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            always_comb begin
                nxt_to_mux[g] = i_pin_analog_enables[g];
                nxt_dig_en[g] = ~i_pin_analog_enables[g];
                nxt_pull[g] = i_port_pullup_en[g] & ~i_pin_analog_enables[g];
                nxt_dir_in[g] = i_port_dir_input[g] | i_pin_analog_enables[g];
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dig_en_ff <= 8'hff;
            dir_in_ff <= 8'hff;
            pull_ff <= 8'h00;
            to_mux_ff <= 8'h00;
        end else begin
            dig_en_ff <= nxt_dig_en;
            dir_in_ff <= nxt_dir_in;
            pull_ff <= nxt_pull;
            to_mux_ff <= nxt_to_mux;
        end
    end

    // ----------------------------------------
    // Input source and reference
    // ----------------------------------------
    adc_seq_pkg::input_src_t src_ff, nxt_src;
    logic [2:0] chan_ff, nxt_chan;
    logic ref_ff, nxt_ref, pwr_ff, nxt_pwr, fmt_ff, nxt_fmt;

    // Mixed codes outside the table float the input rather than short sources
    always_comb begin
        nxt_chan = i_external_channel_select[2:0];
        nxt_src = adc_seq_pkg::SRC_FLOAT;
        if (i_internal_source_select == `SRC_BANDGAP) begin
            if (i_external_channel_select[3]) begin
                nxt_src = adc_seq_pkg::SRC_BANDGAP;
            end
        end else if (i_internal_source_select >= `SRC_GND_LO &&
                     i_internal_source_select <= `SRC_GND_HI) begin
            if (i_external_channel_select[3]) begin
                nxt_src = adc_seq_pkg::SRC_GROUND;
            end
        end else if (!i_external_channel_select[3]) begin
            nxt_src = adc_seq_pkg::SRC_PIN;
        end else begin
            nxt_src = adc_seq_pkg::SRC_FLOAT;
        end
        nxt_ref = (i_reference_source_select == `REF_SUPPLY_CODE);
        nxt_pwr = i_converter_power_enable;
        nxt_fmt = i_result_format_select;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            src_ff <= adc_seq_pkg::SRC_FLOAT;
            chan_ff <= 3'h0;
            ref_ff <= 1'b0;
            pwr_ff <= 1'b0;
            fmt_ff <= 1'b0;
        end else begin
            src_ff <= nxt_src;
            chan_ff <= nxt_chan;
            ref_ff <= nxt_ref;
            pwr_ff <= nxt_pwr;
            fmt_ff <= nxt_fmt;
        end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    adc_tick_if tick_bus ();
    adc_clk_divider u_div (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .tick_bus(tick_bus.gen)
    );

    adc_seq_pkg::seq_state_t st_ff, nxt_st;
    logic [4:0] cnt_ff, nxt_cnt;
    logic busy_ff, nxt_busy, flag_ff, nxt_flag, irq_ff, nxt_irq;
    logic hold_ff, nxt_hold, crst_ff, nxt_crst;
    logic [11:0] res_ff, nxt_res;
    logic done;

    assign tick_bus.div_sel = i_conv_clock_divider;
    assign tick_bus.restart = i_start;

    // Runs on its own; processor sees busy, flag, interrupt and result
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_res = res_ff;
        done = 1'b0;
        unique case (st_ff)
            adc_seq_pkg::ST_IDLE: begin
                if (i_start) begin
                    nxt_st = adc_seq_pkg::ST_ARMED;
                end
            end
            adc_seq_pkg::ST_ARMED: begin
                if (!i_start) begin
                    nxt_st = adc_seq_pkg::ST_SAMPLE;
                    nxt_cnt = 5'h00;
                end
            end
            adc_seq_pkg::ST_SAMPLE: begin
                if (tick_bus.tick) begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == `SAMPLE_CYCLES - 5'h01) begin
                        nxt_st = adc_seq_pkg::ST_CONVERT;
                    end
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (tick_bus.tick) begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == `TOTAL_CYCLES - 5'h01) begin
                        nxt_st = adc_seq_pkg::ST_IDLE;
                        nxt_res = i_core_result;
                        done = 1'b1;
                    end
                end
            end
        endcase
        if (i_start && st_ff != adc_seq_pkg::ST_IDLE) begin
            nxt_st = adc_seq_pkg::ST_ARMED;
            done = 1'b0;
            nxt_res = res_ff;
        end
        if (!i_converter_power_enable) begin
            nxt_st = adc_seq_pkg::ST_IDLE;
            done = 1'b0;
            nxt_res = res_ff;
        end
        nxt_busy = (nxt_st == adc_seq_pkg::ST_SAMPLE) || (nxt_st == adc_seq_pkg::ST_CONVERT);
        nxt_flag = done | (flag_ff & ~i_irq_flag_clear);
        nxt_irq = nxt_flag & i_conversion_irq_enable & i_global_irq_enable;
        nxt_hold = (nxt_st == adc_seq_pkg::ST_CONVERT);
        nxt_crst = (nxt_st == adc_seq_pkg::ST_ARMED);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= adc_seq_pkg::ST_IDLE;
            cnt_ff <= 5'h00;
            busy_ff <= 1'b0;
            flag_ff <= 1'b0;
            irq_ff <= 1'b0;
            hold_ff <= 1'b0;
            crst_ff <= 1'b0;
            res_ff <= `RESULT_RESET;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            flag_ff <= nxt_flag;
            irq_ff <= nxt_irq;
            hold_ff <= nxt_hold;
            crst_ff <= nxt_crst;
            res_ff <= nxt_res;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_pin_digital_enable = dig_en_ff;
    assign o_pin_dir_input = dir_in_ff;
    assign o_pin_pullup_on = pull_ff;
    assign o_pin_to_mux = to_mux_ff;
    assign o_input_source = src_ff;
    assign o_channel_index = chan_ff;
    assign o_ref_from_supply = ref_ff;
    assign o_analog_power_on = pwr_ff;
    assign o_sample_hold = hold_ff;
    assign o_core_reset = crst_ff;
    assign o_conversion_busy_flag = busy_ff;
    assign o_conversion_irq_flag = flag_ff;
    assign o_conversion_irq = irq_ff;
    assign o_result_format = fmt_ff;
    assign o_result_high_reg = {4'h0, res_ff[11:8]};
    assign o_result_low_reg = res_ff[7:0];
endmodule

// File: adc_seq_assertions.sv
// Purpose: Port checks for the input select and sequencer
// Assumes: One core clock, async active-low reset
// Notes: Sees only top-level ports
`timescale 1ns/10ps
module adc_seq_checker (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Watched inputs
    input wire logic [7:0] i_pin_analog_enables,
    input wire logic i_converter_power_enable,
    input wire logic i_start,
    input wire logic [2:0] i_conv_clock_divider,
    input wire logic [1:0] i_reference_source_select,
    input wire logic i_global_irq_enable,
    input wire logic i_conversion_irq_enable,
    // Watched outputs
    input wire logic [7:0] o_pin_digital_enable,
    input wire logic [7:0] o_pin_dir_input,
    input wire logic [7:0] o_pin_pullup_on,
    input wire logic [7:0] o_pin_to_mux,
    input wire logic o_ref_from_supply,
    input wire logic o_analog_power_on,
    input wire logic o_core_reset,
    input wire logic o_conversion_busy_flag,
    input wire logic o_conversion_irq_flag,
    input wire logic o_conversion_irq,
    input wire logic [7:0] o_result_low_reg
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    // ----------
    // Busy length
    // ----------
    // Counter avoids a long repetition the tools would unroll
    logic [11:0] busy_cnt_ff;
    logic [11:0] nxt_busy_cnt;
    always_comb nxt_busy_cnt = o_conversion_busy_flag ? busy_cnt_ff + 12'h001 : 12'h000;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) busy_cnt_ff <= 12'h000;
        else busy_cnt_ff <= nxt_busy_cnt;
    end
    sequence done_s;
        $fell(o_conversion_busy_flag) && $past(i_converter_power_enable) && !$past(i_start);
    endsequence
    pin_mux_a: assert property (o_pin_to_mux == $past(i_pin_analog_enables)
        && o_pin_digital_enable == ~o_pin_to_mux) else $error("pin mux wrong");
    pullup_off_a: assert property ((o_pin_pullup_on & o_pin_to_mux) == 8'h00)
        else $error("pull-up left on");
    dir_override_a: assert property ((o_pin_to_mux & ~o_pin_dir_input) == 8'h00)
        else $error("direction not overridden");
    // Length scales with the divider code, which stays put across a run
    conv_len_a: assert property (done_s |-> busy_cnt_ff == (12'h010 << i_conv_clock_divider))
        else $error("busy length wrong");
    done_flag_a: assert property (done_s |-> o_conversion_irq_flag)
        else $error("flag not set at completion");
    irq_gate_a: assert property (o_conversion_irq |-> o_conversion_irq_flag
        && $past(i_global_irq_enable) && $past(i_conversion_irq_enable)) else $error("irq not gated");
    result_hold_a: assert property ($changed(o_result_low_reg) |-> $fell(o_conversion_busy_flag))
        else $error("result changed mid-run");
    power_off_a: assert property (!$past(i_converter_power_enable)
        |-> !o_analog_power_on && !o_conversion_busy_flag) else $error("power off ignored");
    start_arm_a: assert property (i_start && i_converter_power_enable && o_analog_power_on
        |=> o_core_reset && !o_conversion_busy_flag) else $error("start high not arming");
    ref_sel_a: assert property (o_ref_from_supply == ($past(i_reference_source_select) == 2'h1))
        else $error("reference select wrong");
endmodule
bind adc_input_select_and_sequencer adc_seq_checker i_chk (.*);

// File: adc_input_select_and_sequencer_tb.sv
// Purpose: Self-checking bench for the input select and sequencer
// Assumes: 10 MHz clock, inputs driven 1 ns after the edge
// Notes: One task per scenario
`timescale 1ns/10ps
module adc_input_select_and_sequencer_tb;
    logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_converter_power_enable = 1'b0, i_start = 1'b0;
    logic i_result_format_select = 1'b0, i_global_irq_enable = 1'b0, i_conversion_irq_enable = 1'b0;
    logic i_irq_flag_clear = 1'b0;
    logic [7:0] i_pin_analog_enables = 8'h00, i_port_dir_input = 8'h00, i_port_pullup_en = 8'h00;
    logic [2:0] i_conv_clock_divider = 3'h0, i_internal_source_select = 3'h0;
    logic [3:0] i_external_channel_select = 4'h0;
    logic [1:0] i_reference_source_select = 2'h0;
    logic [11:0] i_core_result = 12'h000;
    logic [7:0] o_pin_digital_enable, o_pin_dir_input, o_pin_pullup_on, o_pin_to_mux;
    logic [7:0] o_result_high_reg, o_result_low_reg;
    logic [1:0] o_input_source;
    logic [2:0] o_channel_index;
    logic o_ref_from_supply, o_analog_power_on, o_sample_hold, o_core_reset, o_conversion_busy_flag;
    logic o_conversion_irq_flag, o_conversion_irq, o_result_format;
    int n_mismatch = 0, n_tests = 0, n_cyc = 0, n, nh;
    adc_input_select_and_sequencer i_dut (.*);
    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end
    // Hang guard, well above the longest conversion
    always @(posedge i_core_clk) begin
        n_cyc++;
        if (n_cyc == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task wrap_up;
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] exp_src(input logic [2:0] s, input logic [3:0] c);
        if (!c[3]) return (s == 3'h0 || s > 3'h4) ? 2'h1 : 2'h0;
        if (s == 3'h1) return 2'h2;
        return (s > 3'h1 && s < 3'h5) ? 2'h3 : 2'h0;
    endfunction
    task wait_conv;
        for (int k = 0; k < 20 && o_conversion_busy_flag !== 1'b1; k++) cyc(1);
        n = 0;
        nh = 0;
        while (o_conversion_busy_flag === 1'b1 && n < 5000) begin
            n++;
            if (o_sample_hold === 1'b1) nh++;
            cyc(1);
        end
    endtask
    task pulse_start;
        i_start = 1'b1;
        cyc(1);
        chk({o_core_reset, o_conversion_busy_flag}, 2'h2);
        i_start = 1'b0;
    endtask
    task t_pins;
        i_pin_analog_enables = 8'ha5;
        i_port_dir_input = 8'h0f;
        i_port_pullup_en = 8'hff;
        i_result_format_select = 1'b1;
        cyc(2);
        chk(o_pin_digital_enable, 8'h5a);
        chk(o_pin_to_mux, 8'ha5);
        chk(o_pin_pullup_on, 8'h5a);
        chk(o_pin_dir_input, 8'haf);
        chk(o_result_format, 1'b1);
    endtask
    task t_src;
        for (int s = 0; s < 8; s++) begin
            // Nonexistent channel goes out before the internal source changes
            for (int k = 1; k >= 0; k--) begin
                i_external_channel_select = k ? 4'h9 : 4'h3;
                cyc(1);
                i_internal_source_select = s[2:0];
                cyc(2);
                chk(o_input_source, exp_src(s[2:0], i_external_channel_select));
            end
        end
        i_internal_source_select = 3'h6;
        i_external_channel_select = 4'h5;
        cyc(2);
        chk(o_channel_index, 3'h5);
        for (int r = 0; r < 4; r++) begin
            i_reference_source_select = r[1:0];
            cyc(2);
            chk(o_ref_from_supply, r == 1);
        end
    endtask
    task t_conv(input logic [2:0] d, input logic [11:0] res);
        i_conv_clock_divider = d;
        i_core_result = res;
        pulse_start();
        wait_conv();
        chk(n, 16'h10 << d);
        chk(nh, 16'h0c << d);
        chk(o_result_high_reg, {4'h0, res[11:8]});
        chk(o_result_low_reg, res[7:0]);
        chk({o_conversion_irq_flag, o_conversion_irq, o_sample_hold}, 3'h6);
        i_irq_flag_clear = 1'b1;
        cyc(1);
        i_irq_flag_clear = 1'b0;
        cyc(1);
        chk({o_conversion_irq_flag, o_conversion_irq}, 2'h0);
    endtask
    task t_abort;
        i_conv_clock_divider = 3'h0;
        i_conversion_irq_enable = 1'b0;
        i_core_result = 12'h123;
        pulse_start();
        cyc(8);
        i_start = 1'b1;
        cyc(1);
        chk({o_conversion_busy_flag, o_core_reset}, 2'h1);
        chk(o_result_low_reg, 8'h5a);
        i_start = 1'b0;
        wait_conv();
        chk(n, 16'h10);
        chk(nh, 16'h0c);
        chk(o_result_low_reg, 8'h23);
        chk({o_conversion_irq_flag, o_conversion_irq}, 2'h2);
    endtask
    task t_power;
        i_irq_flag_clear = 1'b1;
        cyc(1);
        i_irq_flag_clear = 1'b0;
        pulse_start();
        cyc(6);
        i_converter_power_enable = 1'b0;
        cyc(2);
        chk({o_conversion_busy_flag, o_analog_power_on}, 2'h0);
        cyc(20);
        chk(o_conversion_irq_flag, 1'b0);
        i_converter_power_enable = 1'b1;
        cyc(2);
    endtask
    initial begin
        cyc(8);
        chk(o_pin_digital_enable, 8'hff);
        chk({o_result_high_reg, o_result_low_reg}, 16'h0000);
        i_reset_n = 1'b1;
        cyc(2);
        // Firmware set-up order
        i_conv_clock_divider = 3'h0;
        cyc(1);
        i_converter_power_enable = 1'b1;
        cyc(1);
        i_internal_source_select = 3'h0;
        cyc(1);
        i_pin_analog_enables = 8'h01;
        i_external_channel_select = 4'h0;
        cyc(1);
        i_reference_source_select = 2'h1;
        cyc(1);
        i_result_format_select = 1'b0;
        cyc(1);
        i_global_irq_enable = 1'b1;
        i_conversion_irq_enable = 1'b1;
        cyc(2);
        chk({o_analog_power_on, o_ref_from_supply, o_pin_to_mux}, 10'h301);
        t_pins();
        t_src();
        t_conv(3'h0, 12'hfff);
        for (int d = 1; d < 8; d++) begin
            t_conv(d[2:0], {1'b0, d[2:0], 8'h5a});
        end
        t_abort();
        t_power();
        wrap_up();
    end
endmodule
